// ==== hw/acsp_pkg.sv ====
// shared constants and types of the converter configuration serial port
package acsp_pkg;

    localparam logic [3:0]  INSTR_LAST   = 4'hf;
    localparam logic [3:0]  BYTE_LAST    = 4'h7;
    localparam int          ADDR_W       = 13;
    localparam logic [1:0]  WL_STREAM    = 2'h3;
    localparam logic [1:0]  STRAP_WAIT   = 2'h3;

    localparam logic [12:0] REG_PORT_CFG = 13'h000;
    localparam logic [12:0] REG_CHIP_ID  = 13'h001;
    localparam logic [12:0] REG_GRADE    = 13'h002;
    localparam logic [12:0] REG_CHAN_IDX = 13'h005;
    localparam logic [12:0] REG_PWR      = 13'h008;
    localparam logic [12:0] REG_PLL_EN   = 13'h009;
    localparam logic [12:0] REG_PLL      = 13'h00a;
    localparam logic [12:0] REG_OUT_MODE = 13'h014;
    localparam logic [12:0] REG_OUT_ADJ  = 13'h015;
    localparam logic [12:0] REG_OUT_CLK  = 13'h016;
    localparam logic [12:0] REG_EXT_REF  = 13'h018;
    localparam logic [12:0] REG_OVR      = 13'h111;

    localparam int          LSB_HI       = 6;
    localparam int          LSB_LO       = 1;
    localparam int          SRST_HI      = 5;
    localparam int          SRST_LO      = 2;
    localparam int          PLL_EN_BIT   = 2;
    localparam int          PLL_LOCK_BIT = 7;

    localparam logic [7:0]  CFG_FIXED    = 8'h18;
    localparam logic [7:0]  MASK_PWR     = 8'h03;
    localparam logic [7:0]  MASK_OUT_MOD = 8'h90;
    localparam logic [7:0]  MASK_OUT_ADJ = 8'h30;
    localparam logic [7:0]  MASK_OUT_CLK = 8'h80;
    localparam logic [7:0]  MASK_EXT_REF = 8'h40;
    localparam logic [7:0]  MASK_OVR     = 8'he0;

    localparam logic [1:0]  CHAN_IDX_RST = 2'h0;
    localparam logic [6:0]  PLL_RST      = 7'h00;
    // arbitrary identification values
    localparam logic [7:0]  CHIP_ID_VAL  = 8'h5a;
    localparam logic [7:0]  GRADE_VAL    = 8'h00;
    // sync order {chip select, data, clock}; select idles high
    localparam logic [2:0]  SYNC_RST     = 3'b100;

    typedef struct packed {
        logic [7:0] pwr;
        logic [7:0] out_mode;
        logic [7:0] out_adj;
        logic [7:0] out_clk;
        logic [7:0] ext_ref;
        logic [7:0] ovr;
    } acsp_chan_s;

    typedef struct packed {
        logic             lsb_first;
        logic [1:0]       chan_idx;
        logic             pll_en;
        logic [6:0]       pll;
        acsp_chan_s [1:0] ch;
    } acsp_cfg_s;

    typedef struct packed {
        acsp_cfg_s  cfg;
        logic [1:0] strap_cnt;
        logic       strap_done;
    } acsp_rf_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA  = 2'b10,
        ST_DONE  = 2'b11
    } acsp_st_e;

    typedef struct packed {
        acsp_st_e    st;
        logic        sclk_q;
        logic [3:0]  cnt;
        logic [15:0] sh;
        logic        rd;
        logic [1:0]  wl;
        logic [1:0]  bidx;
        logic [12:0] addr;
        logic [7:0]  tx;
        logic        sdo;
        logic        oe;
        logic        we;
        logic [12:0] waddr;
        logic [7:0]  wdata;
    } acsp_sp_s;

    localparam acsp_chan_s CHAN_RST = '0;

    localparam acsp_rf_s RF_RST = '{
        cfg: '{lsb_first: 1'b0, chan_idx: CHAN_IDX_RST, pll_en: 1'b0,
               pll: PLL_RST, ch: '{CHAN_RST, CHAN_RST}},
        strap_cnt: 2'h0,
        strap_done: 1'b0
    };

    localparam acsp_sp_s SP_RST = '{
        st: ST_IDLE, sclk_q: 1'b0, cnt: 4'h0, sh: 16'h0000, rd: 1'b0,
        wl: 2'h0, bidx: 2'h0, addr: 13'h0000, tx: 8'h00, sdo: 1'b0,
        oe: 1'b0, we: 1'b0, waddr: 13'h0000, wdata: 8'h00
    };

endpackage

// ==== hw/acsp_regfile.sv ====
// byte-wide configuration registers behind the serial port
`timescale 1ns/100ps
`default_nettype none
module acsp_regfile (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_we,
    input  wire logic [12:0]         i_waddr,
    input  wire logic [7:0]          i_wdata,
    input  wire logic [12:0]         i_raddr,
    input  wire logic [1:0]          i_strap,
    input  wire logic                i_port_idle,
    input  wire logic                i_pll_locked,
    output logic      [7:0]          o_rdata,
    output acsp_pkg::acsp_cfg_s      o_cfg
);
    import acsp_pkg::*;

    acsp_rf_s   s_ff;
    acsp_rf_s   nxt_s;
    acsp_chan_s rc;

    always_comb begin
        nxt_s = s_ff;
        // power-on strap of the low multiplier bits, only if port unused
        if (!s_ff.strap_done) begin
            nxt_s.strap_cnt = s_ff.strap_cnt + 2'h1;
            if (s_ff.strap_cnt == STRAP_WAIT) begin
                nxt_s.strap_done = 1'b1;
                if (i_port_idle) begin
                    nxt_s.cfg.pll[1:0] = i_strap;
                end
            end
        end
        if (i_we) begin
            case (i_waddr)
                REG_PORT_CFG: begin
                    nxt_s.cfg.lsb_first = i_wdata[LSB_HI] | i_wdata[LSB_LO];
                    if (i_wdata[SRST_HI] | i_wdata[SRST_LO]) begin
                        nxt_s.cfg.chan_idx = CHAN_IDX_RST;
                        nxt_s.cfg.ch       = '{CHAN_RST, CHAN_RST};
                    end
                end
                REG_CHAN_IDX: nxt_s.cfg.chan_idx = i_wdata[1:0];
                REG_PLL_EN:   nxt_s.cfg.pll_en   = i_wdata[PLL_EN_BIT];
                REG_PLL:      nxt_s.cfg.pll      = i_wdata[6:0];
                default: begin
                    for (int c = 0; c < 2; c++) begin
                        if (s_ff.cfg.chan_idx[c]) begin
                            case (i_waddr)
                                REG_PWR:      nxt_s.cfg.ch[c].pwr      = i_wdata & MASK_PWR;
                                REG_OUT_MODE: nxt_s.cfg.ch[c].out_mode = i_wdata & MASK_OUT_MOD;
                                REG_OUT_ADJ:  nxt_s.cfg.ch[c].out_adj  = i_wdata & MASK_OUT_ADJ;
                                REG_OUT_CLK:  nxt_s.cfg.ch[c].out_clk  = i_wdata & MASK_OUT_CLK;
                                REG_EXT_REF:  nxt_s.cfg.ch[c].ext_ref  = i_wdata & MASK_EXT_REF;
                                REG_OVR:      nxt_s.cfg.ch[c].ovr      = i_wdata & MASK_OVR;
                                default:      nxt_s.cfg.ch[c].pwr      = nxt_s.cfg.ch[c].pwr;
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_ff <= RF_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // per-channel reads come from channel 0 when its index bit is set, otherwise from channel 1
    always_comb begin
        rc = s_ff.cfg.ch[s_ff.cfg.chan_idx[0] ? 1'b0 : 1'b1];
        case (i_raddr)
            REG_PORT_CFG: o_rdata = CFG_FIXED | {1'b0, s_ff.cfg.lsb_first, 4'h0,
                                                 s_ff.cfg.lsb_first, 1'b0};
            REG_CHIP_ID:  o_rdata = CHIP_ID_VAL;
            REG_GRADE:    o_rdata = GRADE_VAL;
            REG_CHAN_IDX: o_rdata = {6'h00, s_ff.cfg.chan_idx};
            REG_PLL_EN:   o_rdata = {5'h00, s_ff.cfg.pll_en, 2'h0};
            REG_PLL:      o_rdata = {i_pll_locked, s_ff.cfg.pll};
            REG_PWR:      o_rdata = rc.pwr;
            REG_OUT_MODE: o_rdata = rc.out_mode;
            REG_OUT_ADJ:  o_rdata = rc.out_adj;
            REG_OUT_CLK:  o_rdata = rc.out_clk;
            REG_EXT_REF:  o_rdata = rc.ext_ref;
            REG_OVR:      o_rdata = rc.ovr;
            default:      o_rdata = 8'h00;
        endcase
    end

    assign o_cfg = s_ff.cfg;
endmodule
`default_nettype wire

// ==== hw/acsp_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module acsp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= RST;
            q_ff    <= RST;
        end else begin
            meta_ff <= i_d;
            q_ff    <= meta_ff;
        end
    end

    assign o_q = q_ff;
endmodule
`default_nettype wire

// ==== hw/acsp_top.sv ====
// three-wire configuration serial port of the dual converter
`timescale 1ns/100ps
`default_nettype none
module acsp_top (
    input  wire logic           i_clk,
    input  wire logic           i_rst,
    input  wire logic           i_sclk,
    input  wire logic           i_chip_select_low,
    input  wire logic           i_sdio_in,
    output logic                o_sdio_out,
    output logic                o_sdio_oe,
    input  wire logic           i_pll_locked,
    output acsp_pkg::acsp_cfg_s o_cfg
);
    import acsp_pkg::*;

    logic [2:0]  pins;
    logic        sclk;
    logic        chip_select_low;
    logic        sdi;
    logic        rise;
    logic        fall;
    logic [7:0]  rdata;
    logic [15:0] instr;
    logic [15:0] sh_in;
    logic [7:0]  byte_in;
    logic [7:0]  tx_byte;
    logic [2:0]  bit_idx;
    logic        last_byte;
    acsp_cfg_s   cfg;
    acsp_sp_s    s_ff;
    acsp_sp_s    nxt_s;

    acsp_sync #(
        .W   (3),
        .RST (SYNC_RST)
    ) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_chip_select_low, i_sdio_in, i_sclk}),
        .o_q   (pins)
    );

    assign chip_select_low  = pins[2];
    assign sdi  = pins[1];
    assign sclk = pins[0];

    acsp_regfile u_regs (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_we         (s_ff.we),
        .i_waddr      (s_ff.waddr),
        .i_wdata      (s_ff.wdata),
        .i_raddr      (s_ff.addr),
        .i_strap      ({sdi, sclk}),
        .i_port_idle  (chip_select_low),
        .i_pll_locked (i_pll_locked),
        .o_rdata      (rdata),
        .o_cfg        (cfg)
    );

    // sampling edges of the host clock
    assign rise = sclk & ~s_ff.sclk_q;
    assign fall = ~sclk & s_ff.sclk_q;

    assign sh_in   = {s_ff.sh[14:0], sdi};
    assign instr   = cfg.lsb_first ? 16'({<<{sh_in}}) : sh_in;
    assign byte_in = cfg.lsb_first ? 8'({<<{sh_in[7:0]}}) : sh_in[7:0];
    assign tx_byte = (s_ff.cnt == 4'h0) ? rdata : s_ff.tx;
    assign bit_idx = cfg.lsb_first ? s_ff.cnt[2:0] : 3'h7 - s_ff.cnt[2:0];
    assign last_byte = (s_ff.wl != WL_STREAM) && (s_ff.bidx == s_ff.wl);

    always_comb begin
        nxt_s        = s_ff;
        nxt_s.we     = 1'b0;
        nxt_s.sclk_q = sclk;
        if (chip_select_low) begin
            nxt_s.oe = 1'b0;
            // a stall is only legal before or between counted data bytes;
            // select rising ends a streaming frame
            if (!(s_ff.st == ST_DATA && s_ff.cnt == 4'h0 && s_ff.wl != WL_STREAM)) begin
                nxt_s.st = ST_IDLE;
            end
        end else begin
            case (s_ff.st)
                ST_IDLE: begin
                    if (rise) begin
                        nxt_s.sh  = sh_in;
                        nxt_s.cnt = 4'h1;
                        nxt_s.st  = ST_INSTR;
                    end
                end
                ST_INSTR: begin
                    if (rise) begin
                        nxt_s.sh  = sh_in;
                        nxt_s.cnt = s_ff.cnt + 4'h1;
                        if (s_ff.cnt == INSTR_LAST) begin
                            nxt_s.rd   = instr[15];
                            nxt_s.wl   = instr[14:13];
                            nxt_s.addr = instr[12:0];
                            nxt_s.cnt  = 4'h0;
                            nxt_s.bidx = 2'h0;
                            nxt_s.st   = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (s_ff.rd && fall) begin
                        if (s_ff.cnt == 4'h0) begin
                            nxt_s.tx = rdata;
                        end
                        nxt_s.sdo = tx_byte[bit_idx];
                        nxt_s.oe  = 1'b1;
                    end
                    if (rise) begin
                        nxt_s.sh  = sh_in;
                        nxt_s.cnt = s_ff.cnt + 4'h1;
                        if (s_ff.cnt == BYTE_LAST) begin
                            if (!s_ff.rd) begin
                                nxt_s.we    = 1'b1;
                                nxt_s.waddr = s_ff.addr;
                                nxt_s.wdata = byte_in;
                            end
                            nxt_s.cnt  = 4'h0;
                            nxt_s.addr = cfg.lsb_first ? s_ff.addr + 13'h0001
                                                       : s_ff.addr - 13'h0001;
                            if (last_byte) begin
                                nxt_s.st = ST_DONE;
                            end else if (s_ff.wl != WL_STREAM) begin
                                nxt_s.bidx = s_ff.bidx + 2'h1;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    // surplus clocks are ignored until select rises
                    nxt_s.oe = 1'b0;
                end
                default: begin
                    nxt_s.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_ff <= SP_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_sdio_out = s_ff.sdo;
    assign o_sdio_oe  = s_ff.oe;
    assign o_cfg      = cfg;
endmodule
`default_nettype wire

// ==== sim/acsp_host.sv ====
// serial master model driving the three-wire port
`timescale 1ns/100ps
`default_nettype none
module acsp_host (
    input  wire logic i_sdio_out,
    input  wire logic i_sdio_oe,
    output logic      o_sclk,
    output logic      o_chip_select_low,
    output logic      o_sdio_in
);
    logic hoe  = 1'b1;
    logic hd   = 1'b1;
    logic flip = 1'b0;
    always #7 flip = ~flip;
    // undriven wire wanders instead of keeping a stale level
    assign o_sdio_in = i_sdio_oe ? i_sdio_out : (hoe ? hd : flip);
    initial begin
        o_sclk = 1'b0;
        o_chip_select_low = 1'b1;
    end
    task automatic bit_io(input logic b, input logic drv, output logic r);
        o_sclk = 1'b0;
        hoe = drv;
        hd = b;
        #32 o_sclk = 1'b1;
        r = i_sdio_out;
        #32;
    endtask
    // offset keeps link edges off the system clock edges
    task automatic xfer(input logic [15:0] ins, input int n, input logic [23:0] d,
                        input logic lsb, input bit stall, output logic [23:0] q);
        logic r;
        #0.3;
        q = 24'h000000;
        o_chip_select_low = 1'b0;
        #32;
        for (int i = 0; i < 16; i++)
            bit_io(ins[lsb ? i : 15 - i], 1'b1, r);
        for (int k = 0; k < n; k++) begin
            for (int j = 0; j < 8; j++) begin
                bit_io(d[8 * k + (lsb ? j : 7 - j)], !ins[15], r);
                q[8 * k + (lsb ? j : 7 - j)] = r;
            end
            if (stall) begin
                o_chip_select_low = 1'b1;
                #100 o_chip_select_low = 1'b0;
                #32;
            end
        end
        #32 o_chip_select_low = 1'b1;
        #32 o_sclk = 1'b0;
        hoe = 1'b1;
    endtask
    task automatic idle(input int n);
        logic r;
        #0.3;
        for (int i = 0; i < n; i++)
            bit_io(i[0], 1'b1, r);
        o_sclk = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== sim/acsp_top_assertions.sv ====
// concurrent checks on the serial port pins and configuration
`timescale 1ns/100ps
`default_nettype none
module acsp_top_assertions (
    input wire logic                i_clk,
    input wire logic                i_rst,
    input wire logic                i_sclk,
    input wire logic                i_chip_select_low,
    input wire logic                i_sdio_in,
    input wire logic                o_sdio_out,
    input wire logic                o_sdio_oe,
    input wire logic                i_pll_locked,
    input wire acsp_pkg::acsp_cfg_s o_cfg
);
    import acsp_pkg::*;
    logic [3:0] up_cnt;
    logic [4:0] rise_cnt;
    logic       sclk_q;
    // raw rises since select fell, ahead of the synchronised view
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            up_cnt   <= 4'h0;
            rise_cnt <= 5'h00;
            sclk_q   <= 1'b0;
        end else begin
            sclk_q <= i_sclk;
            if (up_cnt != 4'hf) begin
                up_cnt <= up_cnt + 4'h1;
            end
            if (i_chip_select_low) begin
                rise_cnt <= 5'h00;
            end else if (i_sclk && !sclk_q && rise_cnt != 5'h1f) begin
                rise_cnt <= rise_cnt + 5'h01;
            end
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_idle_no_drive: assert property (i_chip_select_low [*5] |-> !o_sdio_oe)
        else $error("data pin driven while deselected");
    a_cfg_quiet: assert property (
        (up_cnt == 4'hf && i_chip_select_low) [*8] |=> $stable(o_cfg))
        else $error("configuration moved while deselected");
    a_oe_after_fall: assert property ($rose(o_sdio_oe) |-> !$past(i_sclk, 2))
        else $error("drive began outside clock low phase");
    a_sdo_moves_low: assert property (
        o_sdio_oe && $past(o_sdio_oe) && $changed(o_sdio_out) |-> !$past(i_sclk, 2))
        else $error("read bit changed outside clock low phase");
    a_sdo_holds_rise: assert property (
        o_sdio_oe && i_sclk && !sclk_q |=> (!o_sdio_oe || $stable(o_sdio_out)) [*4])
        else $error("read bit changed around clock rise");
    a_oe_release: assert property ($rose(i_chip_select_low) |-> ##[1:6] !o_sdio_oe)
        else $error("data pin not released after deselect");
    a_reset_defaults: assert property (
        $fell(i_rst) |-> o_cfg.lsb_first == 1'b0 && o_cfg.chan_idx == 2'h0 && !o_sdio_oe)
        else $error("wrong state after reset");
    a_strap_levels: assert property (
        up_cnt == 4'h8 && $past(i_chip_select_low, 5)
        |-> o_cfg.pll[1:0] == {$past(i_sdio_in, 5), $past(i_sclk, 5)})
        else $error("strap levels not captured");
    a_oe_after_instr: assert property ($rose(o_sdio_oe) |-> rise_cnt >= 5'h10)
        else $error("drive began inside instruction");
endmodule
bind acsp_top acsp_top_assertions i_acsp_top_assertions (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(i_sclk),
    .i_chip_select_low(i_chip_select_low), .i_sdio_in(i_sdio_in),
    .o_sdio_out(o_sdio_out), .o_sdio_oe(o_sdio_oe),
    .i_pll_locked(i_pll_locked), .o_cfg(o_cfg));
`default_nettype wire

// ==== sim/acsp_top_tb.sv ====
// self-checking bench of the configuration serial port
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module acsp_top_tb;
    import acsp_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_pll_locked = 1'b0;
    wire logic   sclk, csn, sdi, sdo, oe;
    acsp_cfg_s   cfg;
    int          mismatches = 0;
    int          n_compared = 0;
    logic [23:0] rd;
    logic        lsb = 1'b0;
    always #2.5 i_clk = ~i_clk;
    acsp_top i_acsp_top (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk),
        .i_chip_select_low(csn), .i_sdio_in(sdi), .o_sdio_out(sdo),
        .o_sdio_oe(oe), .i_pll_locked(i_pll_locked), .o_cfg(cfg));
    acsp_host i_acsp_host (.i_sdio_out(sdo), .i_sdio_oe(oe), .o_sclk(sclk),
        .o_chip_select_low(csn), .o_sdio_in(sdi));
    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic xf(input logic rw, input logic [12:0] a, input logic [1:0] wl,
                      input int n, input logic [23:0] d, input bit st);
        @(posedge i_clk);
        i_acsp_host.xfer({rw, wl, a}, n, d, lsb, st, rd);
        repeat (4) @(posedge i_clk);
    endtask
    task automatic t_reset;
        `CHK(cfg.pll, 7'h02)
        `CHK(cfg.lsb_first, 1'b0)
        `CHK(oe, 1'b0)
    endtask
    task automatic t_single;
        xf(1'b0, REG_CHAN_IDX, 2'h0, 1, 24'h000003, 1'b0);
        `CHK(cfg.chan_idx, 2'h3)
    endtask
    task automatic t_stream;
        xf(1'b0, REG_OUT_CLK, WL_STREAM, 3, 24'h903080, 1'b0);
        `CHK(cfg.ch[0].out_clk, 8'h80)
        `CHK(cfg.ch[1].out_adj, 8'h30)
        `CHK(cfg.ch[0].out_mode, 8'h90)
    endtask
    task automatic t_read;
        xf(1'b1, REG_OUT_ADJ, 2'h1, 2, 24'h000000, 1'b0);
        `CHK(rd[15:0], 16'h9030)
        `CHK(oe, 1'b0)
    endtask
    task automatic t_stall;
        xf(1'b0, REG_EXT_REF, 2'h1, 2, 24'h005540, 1'b1);
        `CHK(cfg.ch[1].ext_ref, 8'h40)
    endtask
    task automatic t_count;
        xf(1'b0, REG_PLL_EN, 2'h0, 2, 24'h000304, 1'b0);
        `CHK(cfg.pll_en, 1'b1)
        `CHK(cfg.ch[0].pwr, 8'h00)
    endtask
    task automatic t_idle;
        @(posedge i_clk);
        i_acsp_host.idle(24);
        repeat (8) @(posedge i_clk);
        `CHK(oe, 1'b0)
        `CHK(cfg.chan_idx, 2'h3)
    endtask
    task automatic t_soft;
        xf(1'b0, REG_PORT_CFG, 2'h0, 1, 24'h000024, 1'b0);
        `CHK(cfg.chan_idx, 2'h0)
        `CHK(cfg.ch[0].out_clk, 8'h00)
        `CHK({cfg.pll_en, cfg.pll}, 8'h82)
        i_pll_locked <= 1'b1;
        xf(1'b1, REG_PLL, 2'h0, 1, 24'h000000, 1'b0);
        `CHK(rd[7:0], 8'h82)
    endtask
    task automatic t_lsb;
        xf(1'b0, REG_PORT_CFG, 2'h0, 1, 24'h000042, 1'b0);
        lsb = 1'b1;
        `CHK(cfg.lsb_first, 1'b1)
        xf(1'b0, REG_CHAN_IDX, 2'h0, 1, 24'h000001, 1'b0);
        xf(1'b0, REG_OUT_MODE, WL_STREAM, 2, 24'h002010, 1'b0);
        `CHK(cfg.ch[0].out_adj, 8'h20)
        `CHK(cfg.ch[1].out_mode, 8'h00)
        xf(1'b1, REG_PORT_CFG, 2'h0, 1, 24'h000000, 1'b0);
        `CHK(rd[7:0], 8'h5a)
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (20) @(posedge i_clk);
        t_reset;
        t_single;
        t_stream;
        t_read;
        t_stall;
        t_count;
        t_idle;
        t_soft;
        t_lsb;
        give_verdict;
    end
    initial begin
        #200000;
        mismatches++;
        give_verdict;
    end
endmodule
`default_nettype wire
